// >>> wdt_timer_unit.sv
// wdt_timer_unit: watchdog counter, flags, events and ahb-lite registers
// assumes: single hclk domain; cpu instruction strobes and power-mode
// levels are synchronous; the reset/power controller acts on the pulses
//
// How it works
// RULE1: source is sub clock or sysclk/4
// RULE2: sub clock from crystal or rc oscillator
// RULE3: select field picks 256 to 32768 periods
// RULE4: control bit 7 keeps system clock in idle
// RULE5: disabled only with option off and key 1010
// RULE6: control resets to key 1010, select 111
// RULE7: software should write key 0101 when used
// RULE8: disabled watchdog ignores clear instructions
// RULE9: overflow when running resets device, sets flag
// RULE10: overflow in low power clears pc, sp
// RULE11: pin low, clear sequence, halt clear counter
// RULE12: single mode clears on one instruction
// RULE13: paired mode clears only on alternation
// RULE14: divided sysclk stops when sysclk stops
// RULE15: noisy systems should use the sub clock
// RULE16: halt clears, counting resumes in idle
// RULE17: halt sets, clear instructions clear power-down flag
// RULE18: watchdog reset equals pin reset plus flag
// RULE19: 15-bit counter, overflow at selected bit

`timescale 1ns/10ps

module wdt_timer_unit (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // oscillator ticks, one-cycle pulses
  input wire logic low_crystal_osc_tick,
  input wire logic low_rc_osc_tick,
  // cpu instruction strobes and power mode
  input wire logic single_clear_instr,
  input wire logic first_half_clear_instr,
  input wire logic second_half_clear_instr,
  input wire logic halt_instr,
  input wire logic pwr_sleep,
  input wire logic pwr_idle,
  input wire logic ext_reset_pin_n,
  // results
  output logic wdt_dev_reset,
  output logic wdt_pcsp_clear,
  output logic timeout_flag,
  output logic power_down_flag,
  output logic idle_sysclk_keep,
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;                 // watchdog_control
    logic [3:0] cfg;                  // configuration options
    logic [wdt_pkg::CNT_W-1:0] cnt;   // watchdog counter
    logic to;                         // timeout_flag
    logic pd;                         // power_down_flag
    logic [wdt_pkg::EV_W-1:0] ists;   // sticky events
    logic [wdt_pkg::EV_W-1:0] imsk;   // event mask
    logic wr_pend;                    // write data phase due
    logic [7:0] wr_addr;              // latched write offset
    logic [31:0] rdata;               // read data register
    logic rdy;                        // hreadyout
    logic resp;                       // hresp, always okay
    logic irq;                        // interrupt level
    logic dev_rst;                    // device reset pulse
    logic pcsp;                       // pc and sp clear pulse
  } wdt_state_s;

  localparam wdt_state_s ST_RST = '{
    ctrl: wdt_pkg::CTRL_RST, // RULE6
    cfg: wdt_pkg::CFG_RST,
    rdy: 1'b1,
    default: '0
  };

  wdt_state_s r, n;

  // ----------------------------------------------------------------
  // derived control
  // ----------------------------------------------------------------
  logic wdt_on;          // watchdog running
  logic [2:0] sel;       // timeout_select
  logic low_pwr;         // in sleep or idle
  logic sysclk_run;      // system clock still toggling
  logic src_tick;        // one source clock period elapsed
  logic clr_ok;          // clear instruction accepted
  logic clr_any;         // any counter clear this cycle
  logic ovf;             // counter overflow this cycle
  logic [wdt_pkg::CNT_W-1:0] mask; // bits below the overflow bit
  logic acc;             // address phase taken
  logic [wdt_pkg::EV_W-1:0] ev;    // this cycle's events

  // the key can override a disabling option, and the option a disabling key
  assign wdt_on = r.cfg[wdt_pkg::CFG_EN] ||
                  (r.ctrl[wdt_pkg::CTRL_KEY_HI:0] != wdt_pkg::KEY_OFF); // RULE5
  assign sel = r.ctrl[wdt_pkg::CTRL_SEL_HI:wdt_pkg::CTRL_SEL_LO];
  assign low_pwr = pwr_sleep || pwr_idle;
  // system clock stops in sleep, and in idle unless kept on
  assign sysclk_run = !(pwr_sleep ||
                        (pwr_idle && !r.ctrl[wdt_pkg::CTRL_KEEP_BIT])); // RULE4 RULE14
  // overflow bit 8+sel: mask holds the 8+sel bits below it
  assign mask = wdt_pkg::CNT_FULL >> (3'h7 - sel); // RULE3 RULE19

  // ----------------------------------------------------------------
  // source clock enable
  // ----------------------------------------------------------------
  wdt_src_en u_src (
    .hclk(hclk),
    .hresetn(hresetn),
    .src_sys(r.cfg[wdt_pkg::CFG_SRC_SYS]),
    .sub_rc(r.cfg[wdt_pkg::CFG_SUB_RC]),
    .sysclk_run(sysclk_run),
    .low_crystal_osc_tick(low_crystal_osc_tick),
    .low_rc_osc_tick(low_rc_osc_tick),
    .src_tick(src_tick)
  );

  // ----------------------------------------------------------------
  // clear instruction sequencer
  // ----------------------------------------------------------------
  wdt_clr_seq u_seq (
    .hclk(hclk),
    .hresetn(hresetn),
    .wdt_on(wdt_on),
    .paired(r.cfg[wdt_pkg::CFG_PAIRED]),
    .single_clear_instr(single_clear_instr),
    .first_half_clear_instr(first_half_clear_instr),
    .second_half_clear_instr(second_half_clear_instr),
    .clr_ok(clr_ok)
  );

  // any clear wins over an overflow in the same cycle, so a late but
  // legal clear never turns into a reset
  assign clr_any = !ext_reset_pin_n || clr_ok ||
                   (halt_instr && wdt_on); // RULE11 RULE16
  assign ovf = wdt_on && src_tick && !clr_any &&
               ((r.cnt & mask) == mask); // RULE19
  assign ev = {clr_ok, ovf && low_pwr, ovf && !low_pwr};
  assign acc = hsel && htrans[1] && hready;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.dev_rst = 1'b0;
    n.pcsp = 1'b0;
    n.rdy = 1'b1;
    n.resp = 1'b0;

    // counter: clear, else count one source period when running
    if (clr_any || ovf) begin
      n.cnt = '0; // RULE11 RULE19
    end else if (wdt_on && src_tick) begin
      n.cnt = r.cnt + 15'h0001; // RULE16
    end

    // overflow outcome depends on the power mode
    if (ovf) begin
      n.to = 1'b1; // RULE9 RULE10
      n.dev_rst = !low_pwr; // RULE9 RULE18
      n.pcsp = low_pwr; // RULE10
    end else if (halt_instr) begin
      n.to = 1'b0;
    end

    // power-down flag
    if (halt_instr) begin
      n.pd = 1'b1; // RULE17
    end else if (clr_ok) begin
      n.pd = 1'b0; // RULE17
    end

    // register write, in the data phase
    if (r.wr_pend) begin
      case (r.wr_addr)
        wdt_pkg::OFF_CTRL: n.ctrl = hwdata[7:0];
        wdt_pkg::OFF_CFG: n.cfg = hwdata[3:0];
        wdt_pkg::OFF_ISTS: n.ists = r.ists & ~hwdata[wdt_pkg::EV_W-1:0];
        wdt_pkg::OFF_IMSK: n.imsk = hwdata[wdt_pkg::EV_W-1:0];
        default: n.ctrl = n.ctrl;
      endcase
    end
    // events set after the clear so that a set always wins
    n.ists = n.ists | ev;
    n.irq = |(n.ists & n.imsk);

    // address phase; reads other than the status run bit, which comes from
    // the current ctrl and cfg, see the state as it will be after this
    // edge, so a read right behind a write returns the new value
    n.wr_pend = acc && hwrite;
    n.wr_addr = {haddr[7:2], 2'h0};
    if (acc && !hwrite) begin
      case ({haddr[7:2], 2'h0})
        wdt_pkg::OFF_CTRL: n.rdata = {24'h000000, n.ctrl};
        wdt_pkg::OFF_CFG: n.rdata = {28'h0000000, n.cfg};
        wdt_pkg::OFF_STAT: n.rdata = {29'h00000000, wdt_on, n.pd, n.to};
        wdt_pkg::OFF_ISTS: n.rdata = {29'h00000000, n.ists};
        wdt_pkg::OFF_IMSK: n.rdata = {29'h00000000, n.imsk};
        wdt_pkg::OFF_CNT: n.rdata = {17'h00000, n.cnt};
        default: n.rdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= ST_RST;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign hrdata = r.rdata;
  assign hreadyout = r.rdy;
  assign hresp = r.resp;
  assign wdt_dev_reset = r.dev_rst;
  assign wdt_pcsp_clear = r.pcsp;
  assign timeout_flag = r.to;
  assign power_down_flag = r.pd;
  assign idle_sysclk_keep = r.ctrl[wdt_pkg::CTRL_KEEP_BIT];
  assign irq = r.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // overflow while running, then the reset pulse with the flag
  sequence s_ovf_run;
    ovf && !low_pwr;
  endsequence

  sequence s_rst_out;
    wdt_dev_reset && timeout_flag && !wdt_pcsp_clear && (r.cnt == '0);
  endsequence

  // a first half, a cycle with no second half, then a first half again
  sequence s_first_twice;
    (wdt_on && r.cfg[wdt_pkg::CFG_PAIRED] && first_half_clear_instr)
    ##1 !second_half_clear_instr
    ##1 (wdt_on && r.cfg[wdt_pkg::CFG_PAIRED] && first_half_clear_instr);
  endsequence

  chk_ovf_reset_flag: assert property ( // RULE9 RULE18
    s_ovf_run |=> s_rst_out ##1 !wdt_dev_reset)
    else $error("overflow did not give one reset pulse with flag");

  chk_ovf_low_power: assert property ( // RULE10
    (ovf && low_pwr) |=> (wdt_pcsp_clear && timeout_flag && !wdt_dev_reset))
    else $error("low power overflow did not clear pc and sp only");

  chk_pin_clears_cnt: assert property ( // RULE11
    !ext_reset_pin_n |=> (r.cnt == '0) && !wdt_dev_reset && !wdt_pcsp_clear)
    else $error("reset pin low did not hold the counter at zero");

  chk_halt_sets_pd: assert property ( // RULE17 RULE16
    (halt_instr && wdt_on) |=> power_down_flag && (r.cnt == '0) && !timeout_flag)
    else $error("halt did not clear counter and set power-down flag");

  chk_off_holds_cnt: assert property ( // RULE8
    (!wdt_on && ext_reset_pin_n) |=> (r.cnt == $past(r.cnt)) && !wdt_dev_reset)
    else $error("disabled watchdog changed its counter");

  chk_key_keeps_on: assert property ( // RULE5
    (r.ctrl[wdt_pkg::CTRL_KEY_HI:0] != wdt_pkg::KEY_OFF) |-> wdt_on)
    else $error("non-disable key did not keep watchdog running");

  chk_single_clear: assert property ( // RULE12
    (wdt_on && !r.cfg[wdt_pkg::CFG_PAIRED] && single_clear_instr)
    |=> (r.cnt == '0) && !power_down_flag)
    else $error("single clear did not clear the counter");

  chk_paired_repeat: assert property ( // RULE13
    s_first_twice |-> !clr_ok)
    else $error("repeated first half cleared the counter");

  chk_ovf_at_select: assert property ( // RULE3 RULE19
    ovf |-> ((r.cnt & mask) == mask) && (mask[7:0] == 8'hff) &&
            (mask[14 - (3'h7 - sel)] == 1'b1))
    else $error("overflow not at the selected divide ratio");

  chk_sysclk_stops: assert property ( // RULE14 RULE1
    (r.cfg[wdt_pkg::CFG_SRC_SYS] && !sysclk_run) ##1
    (r.cfg[wdt_pkg::CFG_SRC_SYS] && !sysclk_run) |-> !src_tick)
    else $error("divided system clock ticked while stopped");

  chk_irq_level: assert property (
    (|(r.ists & r.imsk)) |-> irq)
    else $error("unmasked event without interrupt");

endmodule // wdt_timer_unit

// >>> wdt_pkg.sv
// wdt_pkg: shared constants and types of the watchdog timer unit
// assumes: a single 40 MHz hclk domain, 32-bit ahb-lite register access

package wdt_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00; // watchdog_control
  localparam logic [7:0] OFF_CFG = 8'h04;  // configuration options
  localparam logic [7:0] OFF_STAT = 8'h08; // flags and run state
  localparam logic [7:0] OFF_ISTS = 8'h0c; // sticky event status, w1c
  localparam logic [7:0] OFF_IMSK = 8'h10; // event mask
  localparam logic [7:0] OFF_CNT = 8'h14;  // live counter value

  // ----------------------------------------------------------------
  // watchdog_control fields and reset value
  // ----------------------------------------------------------------
  localparam int CTRL_KEEP_BIT = 7; // idle_sysclk_keep
  localparam int CTRL_SEL_HI = 6;   // timeout_select msb
  localparam int CTRL_SEL_LO = 4;   // timeout_select lsb
  localparam int CTRL_KEY_HI = 3;   // soft_disable_key msb
  localparam logic [7:0] CTRL_RST = 8'h7a;
  localparam logic [3:0] KEY_OFF = 4'ha; // key value that allows disable

  // ----------------------------------------------------------------
  // configuration option bits and reset value
  // ----------------------------------------------------------------
  localparam int CFG_EN = 0;      // 1: option enables watchdog
  localparam int CFG_SRC_SYS = 1; // 1: source is system clock / 4
  localparam int CFG_SUB_RC = 2;  // 1: sub clock from low_rc_osc
  localparam int CFG_PAIRED = 3;  // 1: paired clear method
  localparam logic [3:0] CFG_RST = 4'h1;

  // ----------------------------------------------------------------
  // status, event bits, counter
  // ----------------------------------------------------------------
  localparam int ST_TO = 0;     // timeout_flag
  localparam int ST_PD = 1;     // power_down_flag
  localparam int ST_ON = 2;     // watchdog running
  localparam int EV_TO_RUN = 0; // overflow in normal operation
  localparam int EV_TO_LOW = 1; // overflow in sleep or idle
  localparam int EV_CLR = 2;    // software clear accepted
  localparam int EV_W = 3;
  localparam int CNT_W = 15;
  localparam logic [CNT_W-1:0] CNT_FULL = 15'h7fff;
  localparam logic [1:0] SYS_DIV_LAST = 2'h3; // divide by four

  // which half of the paired clear was seen last
  typedef enum logic [1:0] {HALF_NONE, HALF_FIRST, HALF_SECOND} wdt_half_e;

endpackage

// >>> wdt_src_en.sv
// wdt_src_en: makes the watchdog source-clock enable pulse
// assumes: oscillator ticks are one-cycle pulses synchronous to hclk

`timescale 1ns/10ps

module wdt_src_en (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // selection
  input wire logic src_sys,
  input wire logic sub_rc,
  input wire logic sysclk_run,
  // oscillator ticks
  input wire logic low_crystal_osc_tick,
  input wire logic low_rc_osc_tick,
  // result
  output logic src_tick
);

  typedef struct packed {
    logic [1:0] div; // system clock divider
    logic tick;      // registered source pulse
  } wdt_src_s;

  wdt_src_s r, n;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.tick = 1'b0;
    // divider freezes with the system clock; that stall is deliberate
    if (sysclk_run) begin
      n.div = r.div + 2'h1;
    end
    if (src_sys) begin
      n.tick = sysclk_run && (r.div == wdt_pkg::SYS_DIV_LAST); // RULE1 RULE14
    end else begin
      n.tick = sub_rc ? low_rc_osc_tick : low_crystal_osc_tick; // RULE1 RULE2
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign src_tick = r.tick;

endmodule // wdt_src_en

// >>> wdt_clr_seq.sv
// wdt_clr_seq: decides whether a clear instruction clears the counter
// assumes: instruction strobes are one-cycle pulses, at most one per cycle

`timescale 1ns/10ps

module wdt_clr_seq (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // mode
  input wire logic wdt_on,
  input wire logic paired,
  // instruction strobes
  input wire logic single_clear_instr,
  input wire logic first_half_clear_instr,
  input wire logic second_half_clear_instr,
  // result, same cycle as the strobe
  output logic clr_ok
);

  typedef struct packed {
    wdt_pkg::wdt_half_e last; // last half executed
  } wdt_seq_s;

  wdt_seq_s r, n;

  // ----------------------------------------------------------------
  // decision and history
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    clr_ok = 1'b0;
    if (!wdt_on) begin
      clr_ok = 1'b0; // RULE8
    end else if (!paired) begin
      clr_ok = single_clear_instr; // RULE12
    end else if (first_half_clear_instr) begin
      clr_ok = (r.last == wdt_pkg::HALF_SECOND); // RULE13
      n.last = wdt_pkg::HALF_FIRST;
    end else if (second_half_clear_instr) begin
      clr_ok = (r.last == wdt_pkg::HALF_FIRST); // RULE13
      n.last = wdt_pkg::HALF_SECOND;
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '{last: wdt_pkg::HALF_NONE};
    end else begin
      r <= n;
    end
  end

endmodule // wdt_clr_seq

// >>> wdt_timer_unit_tb_top.sv
// wdt_timer_unit_tb_top: self-checking bench for the watchdog timer unit
// assumes: wdt_pkg compiled first; bench is the only ahb-lite master and
// drives oscillator ticks, instruction strobes and power levels itself

`timescale 1ns/10ps

module wdt_timer_unit_tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, rd, v0;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp;
  logic [5:0] strb; // single, first, second, halt, crystal tick, rc tick
  logic pwr_sleep, pwr_idle, ext_reset_pin_n;
  logic wdt_dev_reset, wdt_pcsp_clear, timeout_flag, power_down_flag;
  logic idle_sysclk_keep, irq;
  int fail_count, comparisons, cyc, rst_seen, pcsp_seen, n0;

  wdt_timer_unit dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .low_crystal_osc_tick(strb[4]), .low_rc_osc_tick(strb[5]),
    .single_clear_instr(strb[0]), .first_half_clear_instr(strb[1]),
    .second_half_clear_instr(strb[2]), .halt_instr(strb[3]),
    .pwr_sleep(pwr_sleep), .pwr_idle(pwr_idle), .ext_reset_pin_n(ext_reset_pin_n),
    .wdt_dev_reset(wdt_dev_reset), .wdt_pcsp_clear(wdt_pcsp_clear),
    .timeout_flag(timeout_flag), .power_down_flag(power_down_flag),
    .idle_sysclk_keep(idle_sysclk_keep), .irq(irq)
  );

  // ----------------------------------------------------------------
  // clock, pulse monitors and hang guard
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // the pulses stand one cycle, so they are counted at every edge
  always @(posedge hclk) begin
    cyc++;
    if (wdt_dev_reset === 1'b1) rst_seen++;
    if (wdt_pcsp_clear === 1'b1) pcsp_seen++;
    if (cyc == 60000) begin
      fail_count++;
      $display("CHECK FAILED at %0t: run did not finish in time", $time);
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one single ahb-lite transfer; waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h00000000;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata; // read data is taken at the edge that ends the data phase
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h00000000, rd);
    chk(rd, exp, what);
  endtask

  // n one-cycle pulses on a strobe, one idle cycle between them
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge hclk);
      strb[idx] <= 1'b1;
      @(posedge hclk);
      strb[idx] <= 1'b0;
    end
    repeat (3) @(posedge hclk); // let the registered tick land
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    strb = 6'h00;
    pwr_sleep = 1'b0;
    pwr_idle = 1'b0;
    ext_reset_pin_n = 1'b1;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;

    // reset values, unmapped place, bus response
    rc(wdt_pkg::OFF_CTRL, 32'h0000007a, "control reset");
    rc(wdt_pkg::OFF_CFG, 32'h00000001, "config reset");
    rc(wdt_pkg::OFF_STAT, 32'h00000004, "status reset, key 1010 still runs");
    rc(8'h18, 32'h00000000, "unmapped read");
    chk({31'h0, hresp}, 32'h0, "response okay");
    chk({31'h0, hreadyout}, 32'h1, "no wait states");
    $display("test reset done");

    // overflow after exactly 2^(8+sel) source ticks, normal mode
    for (int s = 0; s < 6; s++) begin
      wr(wdt_pkg::OFF_CTRL, {25'h0, s[2:0], 4'h5});
      pulse(0, 1);
      n0 = rst_seen;
      pulse(4, (256 << s) - 1);
      rc(wdt_pkg::OFF_CNT, (256 << s) - 1, "count before overflow");
      chk(rst_seen - n0, 0, "no early reset");
      pulse(4, 1);
      chk(rst_seen - n0, 1, "device reset on overflow");
      chk({31'h0, timeout_flag}, 32'h1, "timeout flag set");
      rc(wdt_pkg::OFF_CNT, 32'h0, "count wraps to zero");
    end
    rc(wdt_pkg::OFF_ISTS, 32'h00000005, "normal overflow and clear events");
    $display("test overflow done");

    // overflow in sleep: only pc/sp clear
    wr(wdt_pkg::OFF_ISTS, 32'h7);
    wr(wdt_pkg::OFF_CTRL, 32'h05);
    pulse(0, 1);
    pwr_sleep <= 1'b1;
    n0 = rst_seen;
    pulse(4, 256);
    chk(pcsp_seen, 1, "pc/sp clear in sleep");
    chk(rst_seen - n0, 0, "no device reset in sleep");
    rc(wdt_pkg::OFF_ISTS, 32'h00000006, "low power overflow event");
    pwr_sleep <= 1'b0;
    $display("test low power done");

    // sub clock from the rc oscillator
    wr(wdt_pkg::OFF_CTRL, 32'h75);
    wr(wdt_pkg::OFF_CFG, 32'h5);
    pulse(0, 1);
    pulse(4, 10);
    rc(wdt_pkg::OFF_CNT, 32'h0, "crystal ticks ignored");
    pulse(5, 10);
    rc(wdt_pkg::OFF_CNT, 32'd10, "rc ticks counted");

    // system clock divided by four, stopping in sleep and idle without clock
    wr(wdt_pkg::OFF_CFG, 32'h3);
    pulse(0, 1);
    repeat (400) @(posedge hclk);
    bus(1'b0, wdt_pkg::OFF_CNT, 32'h0, rd);
    chk({31'h0, rd >= 99 && rd <= 102}, 32'h1, "sysclk/4 rate");
    pwr_sleep <= 1'b1;
    bus(1'b0, wdt_pkg::OFF_CNT, 32'h0, v0);
    repeat (100) @(posedge hclk);
    rc(wdt_pkg::OFF_CNT, v0, "stopped in sleep");
    pwr_sleep <= 1'b0;
    wr(wdt_pkg::OFF_CTRL, 32'hf5);
    @(posedge hclk); // the write lands at the edge that ends the task
    chk({31'h0, idle_sysclk_keep}, 32'h1, "keep bit output");
    pwr_idle <= 1'b1;
    bus(1'b0, wdt_pkg::OFF_CNT, 32'h0, v0);
    repeat (100) @(posedge hclk);
    bus(1'b0, wdt_pkg::OFF_CNT, 32'h0, rd);
    chk({31'h0, rd - v0 >= 24 && rd - v0 <= 27}, 32'h1, "counts in idle with clock");
    wr(wdt_pkg::OFF_CTRL, 32'h75);
    @(posedge hclk);
    chk({31'h0, idle_sysclk_keep}, 32'h0, "keep bit cleared");
    bus(1'b0, wdt_pkg::OFF_CNT, 32'h0, v0);
    repeat (100) @(posedge hclk);
    rc(wdt_pkg::OFF_CNT, v0, "stopped in idle without clock");
    pwr_idle <= 1'b0;
    $display("test sources done");

    // clear by halt, single instruction, pin; power-down flag; interrupt
    wr(wdt_pkg::OFF_CFG, 32'h1);
    wr(wdt_pkg::OFF_ISTS, 32'h7);
    wr(wdt_pkg::OFF_IMSK, 32'h4);
    pulse(4, 5);
    pulse(3, 1);
    rc(wdt_pkg::OFF_STAT, 32'h00000006, "halt sets power down, clears timeout");
    rc(wdt_pkg::OFF_CNT, 32'h0, "halt clears count");
    chk({31'h0, irq}, 32'h0, "no irq yet");
    pulse(4, 5);
    pulse(0, 1);
    rc(wdt_pkg::OFF_CNT, 32'h0, "single clear");
    chk({31'h0, power_down_flag}, 32'h0, "clear drops power down");
    chk({31'h0, irq}, 32'h1, "irq on clear event");
    wr(wdt_pkg::OFF_ISTS, 32'h4);
    @(posedge hclk);
    chk({31'h0, irq}, 32'h0, "irq after w1c");
    pulse(0, 1);
    wr(wdt_pkg::OFF_IMSK, 32'h0);
    @(posedge hclk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    pulse(4, 5);
    @(posedge hclk);
    ext_reset_pin_n <= 1'b0;
    repeat (2) @(posedge hclk);
    ext_reset_pin_n <= 1'b1;
    rc(wdt_pkg::OFF_CNT, 32'h0, "pin clears count");
    $display("test clears done");

    // paired clear: only alternation clears
    wr(wdt_pkg::OFF_CFG, 32'h9);
    pulse(1, 1);
    pulse(4, 5);
    pulse(1, 2);
    rc(wdt_pkg::OFF_CNT, 32'd5, "repeated first half");
    pulse(2, 1);
    rc(wdt_pkg::OFF_CNT, 32'h0, "second half clears");
    pulse(4, 3);
    pulse(2, 1);
    rc(wdt_pkg::OFF_CNT, 32'd3, "repeated second half");
    pulse(1, 1);
    rc(wdt_pkg::OFF_CNT, 32'h0, "first half clears");
    $display("test paired done");

    // disable needs option off and key 1010
    wr(wdt_pkg::OFF_CFG, 32'h1);
    pulse(3, 1);
    pulse(4, 4);
    wr(wdt_pkg::OFF_ISTS, 32'h7);
    wr(wdt_pkg::OFF_CFG, 32'h0);
    rc(wdt_pkg::OFF_STAT, 32'h00000006, "option off, key 0101 runs");
    wr(wdt_pkg::OFF_CTRL, 32'h7a);
    rc(wdt_pkg::OFF_STAT, 32'h00000002, "disabled");
    pulse(0, 1);
    pulse(4, 3);
    rc(wdt_pkg::OFF_CNT, 32'd4, "clear ignored, count held");
    rc(wdt_pkg::OFF_STAT, 32'h00000002, "power down untouched");
    rc(wdt_pkg::OFF_ISTS, 32'h0, "no clear event");
    $display("test disable done");
    wrap_up();
  end
endmodule // wdt_timer_unit_tb_top
